//--- core_timing_pkg.sv
package core_timing_pkg;
	// Datapath and memory sizes.
	localparam int PC_W        = 12;
	localparam int DATA_W      = 8;
	localparam int WORD_W      = 16;
	localparam int DM_ADDR_W   = 5;
	localparam int DM_WORDS    = 32;
	localparam int STACK_DEPTH = 4;
	localparam int SP_W        = 2;

	// One instruction cycle is this many system clocks; the last phase executes.
	localparam int         CLOCKS_PER_CYCLE = 4;
	localparam logic [1:0] LAST_PHASE       = 2'(CLOCKS_PER_CYCLE - 1);

	// Frequency choices of the fast internal RC oscillator, in MHz.
	localparam int OSC_LOW_MHZ  = 4;
	localparam int OSC_HIGH_MHZ = 8;

	// Special data memory locations.
	localparam logic [4:0] DM_PC_LOW    = 5'h00;
	localparam logic [4:0] DM_TABLE_PTR = 5'h01;
	// Page of program memory that holds constant tables.
	localparam logic [3:0] TABLE_PAGE   = 4'hf;

	// Reset values.
	localparam logic [11:0] PC_RESET  = 12'h000;
	localparam logic [7:0]  ACC_RESET = 8'h00;

	// Instruction word fields.
	localparam int OP_HI    = 15;
	localparam int OP_LO    = 12;
	localparam int SUB_HI   = 11;
	localparam int SUB_LO   = 9;
	localparam int BIT_HI   = 8;
	localparam int BIT_LO   = 6;
	localparam int DEST_POS = 5;
	localparam int IMM_SUB_HI = 10;
	localparam int IMM_SUB_LO = 8;

	// Major opcodes.
	localparam logic [3:0] OP_SYS   = 4'h0;
	localparam logic [3:0] OP_ALU_M = 4'h1;
	localparam logic [3:0] OP_ALU_I = 4'h2;
	localparam logic [3:0] OP_UNARY = 4'h3;
	localparam logic [3:0] OP_BSET  = 4'h4;
	localparam logic [3:0] OP_BCLR  = 4'h5;
	localparam logic [3:0] OP_BSZ   = 4'h6;
	localparam logic [3:0] OP_BSNZ  = 4'h7;
	localparam logic [3:0] OP_SKIP  = 4'h8;
	localparam logic [3:0] OP_CALL  = 4'h9;
	localparam logic [3:0] OP_JUMP  = 4'ha;

	// System sub-operations.
	localparam logic [2:0] SYS_NOP   = 3'h0;
	localparam logic [2:0] SYS_RET   = 3'h1;
	localparam logic [2:0] SYS_INTERRUPT_RETURN  = 3'h2;
	localparam logic [2:0] SYS_HALT  = 3'h3;
	localparam logic [2:0] SYS_TABRD = 3'h4;

	// Two-operand ALU sub-operations.
	localparam logic [2:0] ALU_ADD = 3'h0;
	localparam logic [2:0] ALU_ADC = 3'h1;
	localparam logic [2:0] ALU_SUB = 3'h2;
	localparam logic [2:0] ALU_SBC = 3'h3;
	localparam logic [2:0] ALU_AND = 3'h4;
	localparam logic [2:0] ALU_OR  = 3'h5;
	localparam logic [2:0] ALU_XOR = 3'h6;
	localparam logic [2:0] ALU_MOV = 3'h7;

	// Single-operand sub-operations.
	localparam logic [2:0] UN_INC  = 3'h0;
	localparam logic [2:0] UN_DEC  = 3'h1;
	localparam logic [2:0] UN_CPL  = 3'h2;
	localparam logic [2:0] UN_RR   = 3'h3;
	localparam logic [2:0] UN_RL   = 3'h4;
	localparam logic [2:0] UN_RRC  = 3'h5;
	localparam logic [2:0] UN_RLC  = 3'h6;
	localparam logic [2:0] UN_STA  = 3'h7;

	// Byte skip sub-operations.
	localparam logic [2:0] SK_ZERO = 3'h0;
	localparam logic [2:0] SK_INC  = 3'h1;
	localparam logic [2:0] SK_DEC  = 3'h2;
endpackage

//--- mcu_instruction_timing_core.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE_01: RC oscillator is 4 or 8 MHz.
// RULE_02: Configuration strap is frozen once taken.
// RULE_03: Instruction cycle equals four system clocks.
// RULE_04: Ordinary instructions finish in one cycle.
// RULE_05: Jump, call, returns, table read take two.
// RULE_06: Writing program counter low byte jumps, costs extra.
// RULE_07: Taken skip costs one extra cycle.
// RULE_08: Carry on sum over 255, borrow below 0.
// RULE_09: Increment/decrement by one, to operand or accumulator.
// RULE_10: Logical results set zero flag when zero.
// RULE_11: Rotates by one, with or without carry.
// RULE_12: Call saves return address after the call.
// RULE_13: Jump loads target, saves nothing.
// RULE_14: Conditional skips test byte or bit.
// RULE_15: Bit set/clear touches only chosen bit.
// RULE_16: Table read fetches program memory constants.
// RULE_17: Moves between registers, accumulator, and immediates.
// RULE_18: Power-down instruction enters halted state.
// RULE_19: Interrupt return sets global enable; plain return doesn't.
// RULE_20: Second cycle discards prefetched word, refetches.
module mcu_instruction_timing_core (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Configuration strap and wake request.
	input  wire logic        osc_high_select,
	input  wire logic        wake,
	// Program memory port.
	output logic [11:0]      pm_addr,
	input  wire logic [15:0] pm_rdata,
	// Visible core state.
	output logic [7:0]       acc,
	output logic             carry,
	output logic             zero,
	output logic             global_interrupt_enable,
	output logic             halted,
	output logic             osc_high,
	output logic [7:0]       table_high,
	output logic             retired
);

	////////////////////////////////////////////////////////////////////////////////
	// Whole core state in one record.
	typedef struct packed {
		logic [1:0]                                                   phase;      // Clock within cycle.
		logic [core_timing_pkg::PC_W-1:0]                             pc;         // Next fetch address.
		logic [core_timing_pkg::WORD_W-1:0]                           ir;         // Word to execute.
		logic                                                         ir_valid;   // Word is live.
		logic                                                         second;     // In second cycle.
		logic                                                         tbl_pend;   // Table fetch pending.
		logic [core_timing_pkg::DM_ADDR_W-1:0]                        tbl_dst;    // Table low byte target.
		logic [7:0]                                                   tblh;       // Table high byte.
		logic [7:0]                                                   acc;        // Accumulator.
		logic                                                         carry;      // Carry or borrow.
		logic                                                         zero;       // Zero flag.
		logic                                                         gie;        // Global enable.
		logic                                                         halted;     // Powered down.
		logic [core_timing_pkg::STACK_DEPTH-1:0][core_timing_pkg::PC_W-1:0] stack; // Return stack.
		logic [core_timing_pkg::SP_W-1:0]                             sp;         // Stack pointer.
		logic [core_timing_pkg::DM_WORDS-1:0][7:0]                    mem;        // Data memory.
		logic [core_timing_pkg::PC_W-1:0]                             pm_addr;    // Address driven out.
		logic                                                         retired;    // Retire pulse.
		logic                                                         osc_high;   // Frozen strap.
		logic                                                         cfg_taken;  // Strap captured.
	} core_state_type;

	core_state_type state_r;   // Registered state.
	core_state_type state_nxt; // Next state.

	////////////////////////////////////////////////////////////////////////////////
	// Two-operand ALU; bit 8 is carry for sums and borrow for differences.
	function automatic logic [8:0] alu_calc(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] r;
		r = 9'h000;
		case (op)
			core_timing_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
			core_timing_pkg::ALU_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			core_timing_pkg::ALU_SUB: r = {1'b0, a} - {1'b0, b};
			core_timing_pkg::ALU_SBC: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			core_timing_pkg::ALU_AND: r = {1'b0, a & b};
			core_timing_pkg::ALU_OR:  r = {1'b0, a | b};
			core_timing_pkg::ALU_XOR: r = {1'b0, a ^ b};
			default:                  r = {1'b0, b};
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic; instructions execute on the last phase of each cycle.
	always_comb begin
		logic [15:0] w;
		logic [2:0]  sub;
		logic [4:0]  ma;
		logic [7:0]  md;
		logic [8:0]  ar;
		logic [7:0]  res;
		logic        to_mem;
		logic        wr_en;
		logic [4:0]  wr_addr;
		logic [7:0]  wr_data;
		logic        flush;
		logic [11:0] target;
		logic [11:0] here;
		logic [3:0]  op;
		logic [2:0]  isub;
		logic [2:0]  bi;
		// Fields of the word in hand, decoded once.
		w         = state_r.ir;
		op        = w[core_timing_pkg::OP_HI:core_timing_pkg::OP_LO];
		isub      = w[core_timing_pkg::IMM_SUB_HI:core_timing_pkg::IMM_SUB_LO];
		bi        = w[core_timing_pkg::BIT_HI:core_timing_pkg::BIT_LO];
		sub       = w[core_timing_pkg::SUB_HI:core_timing_pkg::SUB_LO];
		ma        = w[core_timing_pkg::DM_ADDR_W-1:0];
		to_mem    = w[core_timing_pkg::DEST_POS];
		here      = state_r.pc - 12'h001;
		md        = (ma == core_timing_pkg::DM_PC_LOW) ? here[7:0] : state_r.mem[ma];
		ar        = 9'h000;
		res       = 8'h00;
		wr_en     = 1'b0;
		wr_addr   = ma;
		wr_data   = 8'h00;
		flush     = 1'b0;
		target    = state_r.pc;
		state_nxt = state_r;
		state_nxt.retired = 1'b0;
		state_nxt.phase   = state_r.phase + 2'h1; // RULE_03
		// The strap is taken once after reset and never written again.
		if (!state_r.cfg_taken) begin
			state_nxt.osc_high  = osc_high_select; // RULE_01
			state_nxt.cfg_taken = 1'b1;            // RULE_02
		end
		if (state_r.phase == core_timing_pkg::LAST_PHASE) begin // RULE_03
			if (state_r.halted) begin
				// Powered down: nothing executes until a wake request.
				if (wake) begin
					state_nxt.halted = 1'b0;
				end
			end else if (state_r.tbl_pend) begin
				// Second cycle of a table read: the constant arrives now.
				state_nxt.mem[state_r.tbl_dst] = pm_rdata[7:0];  // RULE_16
				state_nxt.tblh     = pm_rdata[15:8];             // RULE_16
				state_nxt.tbl_pend = 1'b0;
				state_nxt.retired  = 1'b1;                       // RULE_05
			end else begin
				// Default flow: take the prefetched word and move on.
				state_nxt.ir       = pm_rdata;
				state_nxt.ir_valid = 1'b1;
				state_nxt.pc       = state_r.pc + 12'h001;
				state_nxt.second   = 1'b0;
				state_nxt.retired  = state_r.ir_valid | state_r.second; // RULE_04
				if (state_r.ir_valid) begin
					case (op)
						core_timing_pkg::OP_SYS: begin
							case (sub)
								core_timing_pkg::SYS_RET: begin
									// Plain return leaves the global enable alone.
									state_nxt.sp = state_r.sp - 2'h1;
									target       = state_r.stack[state_r.sp - 2'h1]; // RULE_12
									flush        = 1'b1;                             // RULE_05
								end
								core_timing_pkg::SYS_INTERRUPT_RETURN: begin
									state_nxt.sp  = state_r.sp - 2'h1;
									target        = state_r.stack[state_r.sp - 2'h1];
									state_nxt.gie = 1'b1; // RULE_19
									flush         = 1'b1; // RULE_05
								end
								core_timing_pkg::SYS_HALT: begin
									state_nxt.halted = 1'b1; // RULE_18
								end
								core_timing_pkg::SYS_TABRD: begin
									// Next cycle drives the table address instead of a fetch.
									state_nxt.tbl_pend = 1'b1; // RULE_05
									state_nxt.tbl_dst  = ma;
									state_nxt.retired  = 1'b0;
								end
								default: begin
									// No operation.
								end
							endcase
						end
						core_timing_pkg::OP_ALU_M: begin
							ar = alu_calc(sub, state_r.acc, md, state_r.carry);
							// Arithmetic reports carry or borrow; logic only zero.
							if (sub <= core_timing_pkg::ALU_SBC) begin
								state_nxt.carry = ar[8]; // RULE_08
							end
							if (sub != core_timing_pkg::ALU_MOV) begin
								state_nxt.zero = (ar[7:0] == 8'h00); // RULE_10
							end
							if (to_mem && sub != core_timing_pkg::ALU_MOV) begin
								wr_en   = 1'b1;
								wr_data = ar[7:0];
							end else begin
								state_nxt.acc = ar[7:0]; // RULE_17
							end
						end
						core_timing_pkg::OP_ALU_I: begin
							ar = alu_calc(isub,
								state_r.acc, w[7:0], state_r.carry);
							if (isub <= core_timing_pkg::ALU_SBC) begin
								state_nxt.carry = ar[8]; // RULE_08
							end
							if (isub != core_timing_pkg::ALU_MOV) begin
								state_nxt.zero = (ar[7:0] == 8'h00); // RULE_10
							end
							state_nxt.acc = ar[7:0]; // RULE_17
						end
						core_timing_pkg::OP_UNARY: begin
							case (sub)
								core_timing_pkg::UN_INC: res = md + 8'h01; // RULE_09
								core_timing_pkg::UN_DEC: res = md - 8'h01; // RULE_09
								core_timing_pkg::UN_CPL: res = ~md;
								core_timing_pkg::UN_RR:  res = {md[0], md[7:1]}; // RULE_11
								core_timing_pkg::UN_RL:  res = {md[6:0], md[7]}; // RULE_11
								core_timing_pkg::UN_RRC: res = {state_r.carry, md[7:1]}; // RULE_11
								core_timing_pkg::UN_RLC: res = {md[6:0], state_r.carry}; // RULE_11
								default:                 res = state_r.acc;
							endcase
							// Rotates through carry move the shifted-out bit into carry.
							if (sub == core_timing_pkg::UN_RRC) begin
								state_nxt.carry = md[0]; // RULE_11
							end
							if (sub == core_timing_pkg::UN_RLC) begin
								state_nxt.carry = md[7]; // RULE_11
							end
							if (sub <= core_timing_pkg::UN_CPL) begin
								state_nxt.zero = (res == 8'h00); // RULE_10
							end
							if (to_mem || sub == core_timing_pkg::UN_STA) begin
								wr_en   = 1'b1; // RULE_17
								wr_data = res;
							end else begin
								state_nxt.acc = res; // RULE_09
							end
						end
						core_timing_pkg::OP_BSET, core_timing_pkg::OP_BCLR: begin
							// Read, change one bit, write back the whole byte.
							res = md;
							res[bi] =
								(op == core_timing_pkg::OP_BSET); // RULE_15
							wr_en   = 1'b1;
							wr_data = res;
						end
						core_timing_pkg::OP_BSZ, core_timing_pkg::OP_BSNZ: begin
							// Skip when the tested bit matches the sense of the opcode.
							if (md[bi] ==
								(op == core_timing_pkg::OP_BSNZ)) begin
								target = state_r.pc + 12'h001; // RULE_14
								flush  = 1'b1;                 // RULE_07
							end
						end
						core_timing_pkg::OP_SKIP: begin
							case (sub)
								core_timing_pkg::SK_INC: res = md + 8'h01;
								core_timing_pkg::SK_DEC: res = md - 8'h01;
								default:                 res = md;
							endcase
							// The byte result goes to the accumulator, or with the memory destination to memory for the increment and decrement forms and nowhere for the zero test.
							if (to_mem) begin
								wr_en   = (sub != core_timing_pkg::SK_ZERO);
								wr_data = res;
							end else begin
								state_nxt.acc = res;
							end
							if (res == 8'h00) begin
								target = state_r.pc + 12'h001; // RULE_14
								flush  = 1'b1;                 // RULE_07
							end
						end
						core_timing_pkg::OP_CALL: begin
							state_nxt.stack[state_r.sp] = state_r.pc; // RULE_12
							state_nxt.sp = state_r.sp + 2'h1;
							target       = w[11:0];
							flush        = 1'b1; // RULE_05
						end
						core_timing_pkg::OP_JUMP: begin
							target = w[11:0]; // RULE_13
							flush  = 1'b1;    // RULE_05
						end
						default: begin
							// Unused opcodes act as no operation.
						end
					endcase
				end
				// A data write to the program counter low byte becomes a jump.
				if (wr_en) begin
					if (wr_addr == core_timing_pkg::DM_PC_LOW) begin
						target = {state_r.pc[11:8], wr_data}; // RULE_06
						flush  = 1'b1;                        // RULE_06
					end else begin
						state_nxt.mem[wr_addr] = wr_data;
					end
				end
				// Flow change: drop the prefetched word and fetch at the target.
				if (flush) begin
					state_nxt.pc       = target; // RULE_20
					state_nxt.ir_valid = 1'b0;   // RULE_20
					state_nxt.second   = 1'b1;
					state_nxt.retired  = 1'b0;
				end
			end
			// Address for the coming cycle: a table entry or the next fetch.
			if (state_nxt.tbl_pend) begin
				state_nxt.pm_addr = {core_timing_pkg::TABLE_PAGE,
					state_r.mem[core_timing_pkg::DM_TABLE_PTR]}; // RULE_16
			end else begin
				state_nxt.pm_addr = state_nxt.pc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register with synchronous reset.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r           <= '0;
			state_r.pc        <= core_timing_pkg::PC_RESET;
			state_r.pm_addr   <= core_timing_pkg::PC_RESET;
			state_r.acc       <= core_timing_pkg::ACC_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.
	assign pm_addr                 = state_r.pm_addr;
	assign acc                     = state_r.acc;
	assign carry                   = state_r.carry;
	assign zero                    = state_r.zero;
	assign global_interrupt_enable = state_r.gie;
	assign halted                  = state_r.halted;
	assign osc_high                = state_r.osc_high;
	assign table_high              = state_r.tblh;
	assign retired                 = state_r.retired;

endmodule

//--- core_timing_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the instruction timing core.
module core_timing_checker (
	// Clock and reset.
	input wire logic        clock,
	input wire logic        rst_n,
	// Strap and wake.
	input wire logic        osc_high_select,
	input wire logic        wake,
	// Program memory port.
	input wire logic [11:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	// Core state.
	input wire logic [7:0]  acc,
	input wire logic        carry,
	input wire logic        zero,
	input wire logic        global_interrupt_enable,
	input wire logic        halted,
	input wire logic        osc_high,
	input wire logic [7:0]  table_high,
	input wire logic        retired
);
	// All checks run on the system clock and sleep through reset.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// A new fetch address holds for the rest of its four-clock cycle.
	property p_addr_hold; $changed(pm_addr) |=> $stable(pm_addr) [*3]; endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved inside a cycle");
	// Two completions are at least one instruction cycle apart.
	property p_retire_gap; retired |=> !retired [*3]; endproperty
	a_retire_gap: assert property (p_retire_gap) else $error("completions closer than four clocks");
	// The strap is taken at the first edge after reset.
	property p_osc_take; $past(rst_n) && !$past(rst_n, 2) |-> osc_high == $past(osc_high_select); endproperty
	a_osc_take: assert property (p_osc_take) else $error("oscillator choice not taken from strap");
	// Once taken, the oscillator choice never moves.
	property p_osc_hold; $past(rst_n) && $past(rst_n, 2) |-> $stable(osc_high); endproperty
	a_osc_hold: assert property (p_osc_hold) else $error("oscillator choice changed at run time");
	// The interrupt enable rises in a return's first cycle, completion follows.
	property p_gie_rise; $rose(global_interrupt_enable) |-> ##4 retired; endproperty
	a_gie_rise: assert property (p_gie_rise) else $error("interrupt enable rose outside a completion");
	// Nothing completes while powered down.
	property p_halt_quiet; halted && $past(halted) |-> !retired; endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("completion while powered down");
	// Fetching stops while powered down.
	property p_halt_hold; halted && $past(halted) |-> $stable(pm_addr); endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("fetch address moved while powered down");
	// A wake request ends power-down within one instruction cycle.
	property p_wake; halted && wake |-> ##[1:4] !halted; endproperty
	a_wake: assert property (p_wake) else $error("wake did not end power-down");

	// Main scenarios seen.
	c_two_cycle: cover property (retired ##1 !retired [*7] ##1 retired);
	c_halt: cover property ($rose(halted));
	c_gie: cover property ($rose(global_interrupt_enable));
endmodule

bind mcu_instruction_timing_core core_timing_checker i_core_timing_checker (
	.clock(clock), .rst_n(rst_n), .osc_high_select(osc_high_select), .wake(wake), .pm_addr(pm_addr),
	.pm_rdata(pm_rdata), .acc(acc), .carry(carry), .zero(zero), .global_interrupt_enable(global_interrupt_enable),
	.halted(halted), .osc_high(osc_high), .table_high(table_high), .retired(retired)
);

//--- prog_mem.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Program memory beside the core: a ROM that the bench fills before reset.
module prog_mem (
	// Fetch port.
	input  wire logic [11:0] pm_addr,
	output logic      [15:0] pm_rdata
);
	// Code and constant tables share one store; tables live in the top page.
	logic [15:0] words [4096];
	// The word answers within the cycle, well before the fetch edge.
	assign pm_rdata = words[pm_addr];
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: builds a program, runs it, checks every completion.
module tb_top;
	// Design ports.
	logic        clock;
	logic        rst_n;
	logic        osc_high_select;
	logic        wake;
	logic [11:0] pm_addr;
	logic [15:0] pm_rdata;
	logic [7:0]  acc;
	logic        carry;
	logic        zero;
	logic        global_interrupt_enable;
	logic        halted;
	logic        osc_high;
	logic [7:0]  table_high;
	logic        retired;
	// Expected length and state of each completed instruction.
	typedef struct {int gap; logic [7:0] a; logic c; logic z; logic g;} exp_type;
	exp_type     exp_q [$];
	exp_type     e;
	// Reference state, counters and saved values.
	logic [7:0]  ma;
	logic        mc;
	logic        mz;
	logic        mg;
	logic        strap;
	logic [7:0]  th;
	logic [11:0] hold;
	logic [31:0] seed;
	int          n_fail;
	int          checks;
	int          cycles;
	int          gap;
	int          p;

	mcu_instruction_timing_core i_mcu_instruction_timing_core (.clock(clock), .rst_n(rst_n),
		.osc_high_select(osc_high_select), .wake(wake), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .acc(acc),
		.carry(carry), .zero(zero), .global_interrupt_enable(global_interrupt_enable), .halted(halted),
		.osc_high(osc_high), .table_high(table_high), .retired(retired));
	prog_mem i_prog_mem (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

	// The 100 MHz system clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Repeatable xorshift source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Word builders for the memory, immediate and far forms.
	function automatic logic [15:0] w_mem(int op, int s, int b, int d, int m);
		return {4'(op), 3'(s), 3'(b), 1'(d), 5'(m)};
	endfunction
	function automatic logic [15:0] w_imm(int s, int x);
		return {4'h2, 1'b0, 3'(s), 8'(x)};
	endfunction
	function automatic logic [15:0] w_far(int op, int t);
		return {4'(op), 12'(t)};
	endfunction
	// Compare a state word, and compare an instruction length.
	task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_gap(input int got, input int exp);
		checks++;
		if (got != exp) begin
			n_fail++;
			$display("unexpected length at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run.
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Place a word at the next address and expect its completion.
	task automatic put(input logic [15:0] w, input int g);
		i_prog_mem.words[p] = w;
		p++;
		exp_q.push_back('{g, ma, mc, mz, mg});
	endtask
	// Two-operand arithmetic and logic on the accumulator.
	task automatic do_alu(input int s, input logic [7:0] b);
		logic [8:0] r;
		case (s)
			0: r = {1'b0, ma} + {1'b0, b};
			1: r = {1'b0, ma} + {1'b0, b} + {8'h00, mc};
			2: r = {1'b0, ma} - {1'b0, b};
			3: r = {1'b0, ma} - {1'b0, b} - {8'h00, mc};
			4: r = {mc, ma & b};
			5: r = {mc, ma | b};
			6: r = {mc, ma ^ b};
			default: r = {mc, b};
		endcase
		ma = r[7:0];
		mc = r[8];
		if (s != 7) mz = (r[7:0] == 8'h00);
	endtask
	// Single-operand work with the result going to the accumulator.
	task automatic do_un(input int s, input logic [7:0] x);
		case (s)
			0: ma = x + 8'h01;
			1: ma = x - 8'h01;
			2: ma = ~x;
			3: ma = {x[0], x[7:1]};
			4: ma = {x[6:0], x[7]};
			5: {ma, mc} = {mc, x};
			default: {mc, ma} = {x, mc};
		endcase
		if (s < 3) mz = (ma == 8'h00);
	endtask

	// Program image with its expected completions, in execution order.
	task automatic build();
		int          cs [6] = '{7, 0, 2, 3, 4, 6};
		logic [7:0]  cx [6] = '{8'hff, 8'h01, 8'h01, 8'h00, 8'h00, 8'h5a};
		int          b;
		int          r;
		logic        tk;
		logic [7:0]  x;
		logic [7:0]  v;
		logic [15:0] tw;
		for (int i = 0; i < 4096; i++) i_prog_mem.words[i] = 16'h0000;
		p = 0;
		for (int i = 0; i < 36; i++) begin
			b = (i < 6) ? cs[i] : int'(rnd() % 8);
			x = (i < 6) ? cx[i] : 8'(rnd());
			do_alu(b, x);
			put(w_imm(b, x), (i == 0) ? 0 : 4);
		end
		v = 8'(rnd());
		ma = v;
		put(w_imm(7, v), 4);
		put(w_mem(3, 7, 0, 1, 4), 4);
		for (int s = 0; s < 7; s++) begin
			do_un(s, v);
			put(w_mem(3, s, 0, 0, 4), 4);
		end
		mz = (v == 8'hff);
		put(w_mem(3, 0, 0, 1, 4), 4);
		b = int'(rnd() % 8);
		put(w_mem(4, 0, b, 1, 4), 4);
		put(w_mem(5, 0, (b + 1) % 8, 1, 4), 4);
		v = ((v + 8'h01) | (8'h01 << b)) & ~(8'h01 << ((b + 1) % 8));
		ma = v;
		put(w_mem(1, 7, 0, 0, 4), 4);
		// One bit test skips and the other falls through.
		for (int o = 6; o < 8; o++) begin
			tk = (v[b] == (o == 7));
			put(w_mem(o, 0, b, 0, 4), tk ? 8 : 4);
			if (tk) begin
				i_prog_mem.words[p] = w_imm(7, 8'h55);
				p++;
			end else begin
				ma = 8'h55;
				put(w_imm(7, 8'h55), 4);
			end
			ma = 8'haa;
			put(w_imm(7, 8'haa), 4);
		end
		// Byte tests: zero skips, nonzero copies.
		put(w_mem(8, 0, 0, 1, 2), 8);
		p++;
		ma = v;
		put(w_mem(8, 0, 0, 0, 4), 4);
		put(w_far(10, 12'h100), 8);
		i_prog_mem.words[p] = w_imm(7, 8'h11);
		p = 32'h0100;
		// Plain return first, then interrupt return.
		for (int k = 1; k < 3; k++) begin
			put(w_far(9, 32'h0200 + 16 * k), 8);
			r = p;
			p = 32'h0200 + 16 * k;
			ma = 8'(k);
			put(w_imm(7, k), 4);
			mg = mg | (k == 2);
			put(w_mem(0, k, 0, 0, 0), 8);
			p = r;
			ma = 8'h77;
			put(w_imm(7, 8'h77), 4);
		end
		ma = 8'h60;
		put(w_imm(7, 8'h60), 4);
		put(w_mem(3, 7, 0, 1, 0), 8);
		i_prog_mem.words[p] = w_imm(7, 8'h11);
		p = (p & 32'h0f00) + 32'h0060;
		x = 8'(rnd());
		tw = 16'(rnd());
		i_prog_mem.words[{4'hf, x}] = tw;
		ma = x;
		put(w_imm(7, x), 4);
		put(w_mem(3, 7, 0, 1, 1), 4);
		put(w_mem(0, 4, 0, 0, 5), 8);
		ma = tw[7:0];
		th = tw[15:8];
		put(w_mem(1, 7, 0, 0, 5), 4);
		put(w_mem(0, 3, 0, 0, 0), 4);
		ma = 8'h3c;
		put(w_imm(7, 8'h3c), 0);
		put(w_mem(0, 3, 0, 0, 0), 4);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Each completion is checked for state, and for length where a nonzero one is expected; a hang ends the run.
	always @(posedge clock) begin
		cycles++;
		gap++;
		if (cycles > 6000) begin
			n_fail++;
			end_of_test();
		end else if (rst_n === 1'b1 && retired === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp_val(12'h001, 12'h000);
			end else begin
				e = exp_q.pop_front();
				if (e.gap != 0) cmp_gap(gap, e.gap);
				cmp_val({1'b0, acc, carry, zero, global_interrupt_enable}, {1'b0, e.a, e.c, e.z, e.g});
			end
			gap = 0;
		end
	end

	// Main sequence: reset, run, power-down, wake, final checks.
	initial begin
		rst_n = 1'b0;
		wake = 1'b0;
		osc_high_select = 1'b0;
		seed = 32'hf9d2f803;
		n_fail = 0;
		checks = 0;
		cycles = 0;
		gap = 0;
		ma = 8'h00;
		mc = 1'b0;
		mz = 1'b0;
		mg = 1'b0;
		build();
		strap = seed[0];
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		osc_high_select <= strap;
		@(posedge clock);
		osc_high_select <= ~strap;
		while (exp_q.size() > 2) @(negedge clock);
		repeat (12) @(negedge clock);
		cmp_val({11'h000, halted}, 12'h001);
		hold = pm_addr;
		repeat (12) @(negedge clock);
		cmp_val(pm_addr, hold);
		cmp_gap(exp_q.size(), 2);
		@(posedge clock);
		wake <= 1'b1;
		while (exp_q.size() > 1) @(negedge clock);
		@(posedge clock);
		wake <= 1'b0;
		while (exp_q.size() > 0) @(negedge clock);
		repeat (20) @(negedge clock);
		cmp_val({11'h000, osc_high}, {11'h000, strap});
		cmp_val({4'h0, table_high}, {4'h0, th});
		end_of_test();
	end
endmodule
